// [hdl/atc_pkg.sv]
package atc_pkg;
  localparam int CW = 16;
  localparam int NH = 6;
  // Byte offsets of the register map
  localparam logic [7:0] OFF_ARR = 8'h00;
  localparam logic [7:0] OFF_CNT = 8'h04;
  localparam logic [7:0] OFF_CR = 8'h0c;
  localparam logic [7:0] OFF_ISR = 8'h10;
  localparam logic [7:0] OFF_ICR = 8'h14;
  localparam logic [7:0] OFF_FLTR = 8'h1c;
  localparam logic [7:0] OFF_DTR = 8'h30;
  localparam logic [2:0][7:0] OFF_CHCR = {8'h2c, 8'h28, 8'h24};
  localparam logic [5:0][7:0] OFF_CCR = {8'h50, 8'h4c, 8'h48, 8'h44, 8'h40, 8'h3c};
  // Control register fields
  localparam int CR_EN = 0;
  localparam int CR_MODE = 4;
  localparam int CR_COMP = 8;
  localparam int CR_TWO_POINT_SELECT = 9;
  // Channel control fields, half b adds b to the base position (2*b for the 2-bit edge field)
  localparam int CH_CS = 0;
  localparam int CH_EDGE = 2;
  localparam int CH_IE = 6;
  localparam int CH_DE = 8;
  // Dead-time register fields
  localparam int DTR_DT = 0;
  localparam int DTR_DEAD_TIME_ENABLE = 8;
  localparam int DTR_MOE = 9;
  // Output control / input filter: 4 bits per half, low 3 shared mode/filter
  localparam int FLT_STRIDE = 4;
  localparam int FLT_POL = 3;
  localparam logic [1:0] MODE_EDGE = 2'h2;
  localparam logic [1:0] MODE_CENTER = 2'h3;
  localparam logic [2:0] OCM_TOGGLE = 3'h4;
  localparam logic [2:0] OCM_PWM1 = 3'h6;
  localparam logic [2:0] OCM_PWM2 = 3'h7;
  localparam logic [15:0] ARR_RST = 16'hffff;
  localparam logic [31:0] CR_RST = 32'h0000_0020;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic down;
    logic [CW-1:0] arr;
    logic [31:0] cr;
    logic [23:0] fltr;
    logic [2:0][9:0] chcr;
    logic [9:0] dtr;
    logic [5:0][CW-1:0] ccr;
    logic [5:0] isr;
    logic [5:0] filt;
    logic [5:0][2:0] fcnt;
    logic [5:0] fprev;
    logic [5:0] ref_q;
    logic [2:0] ref_last;
    logic [2:0][7:0] dtc;
    logic [5:0] pin_out;
    logic [5:0] pin_oe;
    logic [5:0] dma;
    logic irq;
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } atc_state_t;
endpackage : atc_pkg

// [hdl/atc_top.sv]
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Behaviour
// - Mode 0x02 runs edge-aligned up counting
// - Function select 0x01 makes half a capture input
// - Edge select 0x01 captures rising edges
// - Edge select 0x3 captures both edges
// - Per-half digital filter precedes edge detection
// - Enabled timer copies counter on capture edge
// - Interrupt enable gates flag onto request
// - DMA enable lets event raise DMA request
// - Writing zero to clear register clears flag
// - Compare mode 0x4 toggles output on match
// - Compare setting drives output from compare register
// - Polarity bit zero leaves output non-inverted
// - Mode 0x3 counts up then down
// - Complementary bit drives pair from one reference
// - Two-point bit zero uses compare A and B
// - Mode 0x6 PWM1, 0x7 inverse PWM2
// - Dead-time enable inserts programmed dead time when the complementary bit is set
// - Outputs reach pins only with main enable
// - Enable bit starts the counter
module atc_top (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_CLK_GATE_EN,
  input wire logic [5:0] I_CH_IN,
  output logic [5:0] O_CH_OUT,
  output logic [5:0] O_CH_OE,
  output logic [5:0] O_DMA_REQ,
  output logic O_IRQ,
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY
);

  atc_pkg::atc_state_t s;
  atc_pkg::atc_state_t n;

  function automatic logic atc_mapped(input logic [7:0] a);
    logic hit;
    hit = (a == atc_pkg::OFF_ARR) || (a == atc_pkg::OFF_CNT) || (a == atc_pkg::OFF_CR) ||
          (a == atc_pkg::OFF_ISR) || (a == atc_pkg::OFF_ICR) || (a == atc_pkg::OFF_FLTR) ||
          (a == atc_pkg::OFF_DTR);
    for (int i = 0; i < 3; i++) begin
      hit = hit || (a == atc_pkg::OFF_CHCR[i]);
    end
    for (int i = 0; i < atc_pkg::NH; i++) begin
      hit = hit || (a == atc_pkg::OFF_CCR[i]);
    end
    return hit;
  endfunction : atc_mapped

  function automatic logic [31:0] atc_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : atc_merge

  always_comb begin
    logic en;
    logic [1:0] mode;
    logic wr;
    logic [31:0] wv;
    logic [5:0] clr_keep;
    logic [5:0] ev;
    logic [5:0] ie_vec;
    logic [5:0] match;
    logic [5:0] lvl;
    logic act;
    logic cs;
    logic [1:0] edge_sel;
    logic [2:0] ocm;
    logic rise;
    logic fall;
    logic [5:0] ref_in;
    logic [5:0] val;
    logic ch_busy;
    en = 1'b0;
    mode = 2'h0;
    wr = 1'b0;
    wv = 32'h0;
    clr_keep = 6'h3f;
    ev = 6'h0;
    ie_vec = 6'h0;
    match = 6'h0;
    lvl = 6'h0;
    act = 1'b0;
    cs = 1'b0;
    edge_sel = 2'h0;
    ocm = 3'h0;
    rise = 1'b0;
    fall = 1'b0;
    ref_in = 6'h0;
    val = 6'h0;
    ch_busy = 1'b0;
    n = s;
    // Counter is frozen while the module clock is gated
    en = s.cr[atc_pkg::CR_EN] & I_CLK_GATE_EN;
    mode = s.cr[atc_pkg::CR_MODE +: 2];

    // Counter
    if (en) begin
      if (mode == atc_pkg::MODE_CENTER) begin
        if (!s.down) begin
          if (s.cnt >= s.arr) begin
            n.down = 1'b1;
            n.cnt = s.cnt - 16'h1;
          end else begin
            n.cnt = s.cnt + 16'h1;
          end
        end else if (s.cnt == 16'h0) begin
          n.down = 1'b0;
          n.cnt = 16'h1;
        end else begin
          n.cnt = s.cnt - 16'h1;
        end
      end else begin
        // Any other mode value also counts edge-aligned up
        n.down = 1'b0;
        n.cnt = (s.cnt >= s.arr) ? 16'h0 : s.cnt + 16'h1;
      end
    end

    // Register writes, performed once both address and data are held
    wr = s.aw_hold & s.w_hold & ~s.bvalid;
    if (wr) begin
      n.aw_hold = 1'b0;
      n.w_hold = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = atc_mapped(s.aw_addr) ? atc_pkg::RESP_OKAY : atc_pkg::RESP_SLVERR;
      if (I_CLK_GATE_EN) begin
        unique case (s.aw_addr)
          atc_pkg::OFF_ARR: begin
            wv = atc_merge({16'h0, s.arr}, s.w_data, s.w_strb);
            n.arr = wv[15:0];
          end
          atc_pkg::OFF_CNT: begin
            wv = atc_merge({16'h0, s.cnt}, s.w_data, s.w_strb);
            n.cnt = wv[15:0];
          end
          atc_pkg::OFF_CR: n.cr = atc_merge(s.cr, s.w_data, s.w_strb);
          atc_pkg::OFF_ICR: begin
            wv = atc_merge(32'hffff_ffff, s.w_data, s.w_strb);
            clr_keep = wv[5:0];
          end
          atc_pkg::OFF_FLTR: begin
            wv = atc_merge({8'h0, s.fltr}, s.w_data, s.w_strb);
            n.fltr = wv[23:0];
          end
          atc_pkg::OFF_DTR: begin
            wv = atc_merge({22'h0, s.dtr}, s.w_data, s.w_strb);
            n.dtr = wv[9:0];
          end
          default: begin
            for (int c = 0; c < 3; c++) begin
              if (s.aw_addr == atc_pkg::OFF_CHCR[c]) begin
                wv = atc_merge({22'h0, s.chcr[c]}, s.w_data, s.w_strb);
                n.chcr[c] = wv[9:0];
              end
            end
            for (int h = 0; h < atc_pkg::NH; h++) begin
              if (s.aw_addr == atc_pkg::OFF_CCR[h]) begin
                wv = atc_merge({16'h0, s.ccr[h]}, s.w_data, s.w_strb);
                n.ccr[h] = wv[15:0];
              end
            end
          end
        endcase
      end
    end

    // Per half: filter, edge detection, capture, compare, reference
    for (int h = 0; h < atc_pkg::NH; h++) begin
      cs = s.chcr[h/2][atc_pkg::CH_CS + h%2];
      edge_sel = s.chcr[h/2][atc_pkg::CH_EDGE + 2*(h%2) +: 2];
      ie_vec[h] = s.chcr[h/2][atc_pkg::CH_IE + h%2];
      ocm = s.fltr[h*atc_pkg::FLT_STRIDE +: 3];
      // Input must hold a new level for more cycles than the filter value
      if (I_CH_IN[h] == s.filt[h]) begin
        n.fcnt[h] = 3'h0;
      end else if (s.fcnt[h] >= ocm) begin
        n.filt[h] = I_CH_IN[h];
        n.fcnt[h] = 3'h0;
      end else begin
        n.fcnt[h] = s.fcnt[h] + 3'h1;
      end
      n.fprev[h] = s.filt[h];
      rise = s.filt[h] & ~s.fprev[h];
      fall = ~s.filt[h] & s.fprev[h];
      match[h] = (s.cnt == s.ccr[h]);
      if (cs) begin
        // Bit 0 of the edge field picks rising, bit 1 falling
        if (en && ((edge_sel[0] && rise) || (edge_sel[1] && fall))) begin
          n.ccr[h] = s.cnt;
          ev[h] = 1'b1;
        end
      end else begin
        ev[h] = en & match[h];
        if (h % 2 == 0 && !s.cr[atc_pkg::CR_TWO_POINT_SELECT]) begin
          act = (s.cnt >= s.ccr[h]) && (s.cnt < s.ccr[h|1]);
        end else begin
          act = s.cnt < s.ccr[h];
        end
        if (en) begin
          unique case (ocm)
            atc_pkg::OCM_TOGGLE: n.ref_q[h] = s.ref_q[h] ^ match[h];
            atc_pkg::OCM_PWM1: n.ref_q[h] = act;
            atc_pkg::OCM_PWM2: n.ref_q[h] = ~act;
            default: n.ref_q[h] = s.ref_q[h];
          endcase
        end
      end
      n.dma[h] = ev[h] & s.chcr[h/2][atc_pkg::CH_DE + h%2];
    end
    // A new event wins over a clear in the same cycle
    n.isr = (s.isr & clr_keep) | ev;
    n.irq = |(n.isr & ie_vec);

    // Output stage: complementary pairing, dead time, polarity, gate
    for (int c = 0; c < 3; c++) begin
      ref_in[2*c] = s.ref_q[2*c];
      ref_in[2*c+1] = s.ref_q[2*c+1];
      ch_busy = 1'b0;
      if (s.cr[atc_pkg::CR_COMP]) begin
        ref_in[2*c+1] = ~s.ref_q[2*c];
        if (s.ref_q[2*c] != s.ref_last[c]) begin
          n.ref_last[c] = s.ref_q[2*c];
          n.dtc[c] = s.dtr[atc_pkg::DTR_DEAD_TIME_ENABLE] ? s.dtr[atc_pkg::DTR_DT +: 8] : 8'h0;
          ch_busy = s.dtr[atc_pkg::DTR_DEAD_TIME_ENABLE] && (s.dtr[atc_pkg::DTR_DT +: 8] != 8'h0);
        end else if (s.dtc[c] != 8'h0) begin
          n.dtc[c] = s.dtc[c] - 8'h1;
          ch_busy = 1'b1;
        end
      end else begin
        n.ref_last[c] = s.ref_q[2*c];
        n.dtc[c] = 8'h0;
      end
      // Both sides of the pair stay at their inactive level during dead time
      if (ch_busy) begin
        ref_in[2*c] = 1'b0;
        ref_in[2*c+1] = 1'b0;
      end
    end
    for (int h = 0; h < atc_pkg::NH; h++) begin
      val[h] = ref_in[h] ^ s.fltr[h*atc_pkg::FLT_STRIDE + atc_pkg::FLT_POL];
      cs = s.chcr[h/2][atc_pkg::CH_CS + h%2];
      n.pin_oe[h] = s.dtr[atc_pkg::DTR_MOE] & ~cs;
      n.pin_out[h] = n.pin_oe[h] & val[h];
    end

    // Bus handshakes
    if (I_AWVALID && s.awready) begin
      n.aw_hold = 1'b1;
      n.aw_addr = I_AWADDR;
    end
    if (I_WVALID && s.wready) begin
      n.w_hold = 1'b1;
      n.w_data = I_WDATA;
      n.w_strb = I_WSTRB;
    end
    if (s.bvalid && I_BREADY) begin
      n.bvalid = 1'b0;
    end
    // Readies are held low while a write response is pending, so one write at a time
    n.awready = ~n.aw_hold & ~n.bvalid;
    n.wready = ~n.w_hold & ~n.bvalid;
    if (s.rvalid && I_RREADY) begin
      n.rvalid = 1'b0;
    end
    if (I_ARVALID && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp = atc_mapped(I_ARADDR) ? atc_pkg::RESP_OKAY : atc_pkg::RESP_SLVERR;
      n.rdata = 32'h0;
      unique case (I_ARADDR)
        atc_pkg::OFF_ARR: n.rdata = {16'h0, s.arr};
        atc_pkg::OFF_CNT: n.rdata = {16'h0, s.cnt};
        atc_pkg::OFF_CR: n.rdata = s.cr;
        atc_pkg::OFF_ISR: n.rdata = {26'h0, s.isr};
        atc_pkg::OFF_FLTR: n.rdata = {8'h0, s.fltr};
        atc_pkg::OFF_DTR: n.rdata = {22'h0, s.dtr};
        default: begin
          for (int c = 0; c < 3; c++) begin
            if (I_ARADDR == atc_pkg::OFF_CHCR[c]) begin
              n.rdata = {22'h0, s.chcr[c]};
            end
          end
          for (int h = 0; h < atc_pkg::NH; h++) begin
            if (I_ARADDR == atc_pkg::OFF_CCR[h]) begin
              n.rdata = {16'h0, s.ccr[h]};
            end
          end
        end
      endcase
    end
    n.arready = ~n.rvalid;
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      s <= '0;
      s.arr <= atc_pkg::ARR_RST;
      s.cr <= atc_pkg::CR_RST;
    end else begin
      s <= n;
    end
  end

  assign O_CH_OUT = s.pin_out;
  assign O_CH_OE = s.pin_oe;
  assign O_DMA_REQ = s.dma;
  assign O_IRQ = s.irq;
  assign O_AWREADY = s.awready;
  assign O_WREADY = s.wready;
  assign O_BRESP = s.bresp;
  assign O_BVALID = s.bvalid;
  assign O_ARREADY = s.arready;
  assign O_RDATA = s.rdata;
  assign O_RRESP = s.rresp;
  assign O_RVALID = s.rvalid;

endmodule : atc_top

// [verif/atc_monitor.sv]
`timescale 1ns/1ps
module atc_monitor (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic [5:0] O_CH_OUT,
  input wire logic [5:0] O_CH_OE,
  input wire logic [5:0] O_DMA_REQ,
  input wire logic I_AWVALID,
  input wire logic O_AWREADY,
  input wire logic I_WVALID,
  input wire logic O_WREADY,
  input wire logic [1:0] O_BRESP,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic [1:0] O_RRESP,
  input wire logic O_RVALID,
  input wire logic I_RREADY
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  property p_pin_gate; (O_CH_OUT & ~O_CH_OE) == 6'h0; endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("pin value without enable");
  property p_dma_pulse; |O_DMA_REQ |=> (O_DMA_REQ & $past(O_DMA_REQ)) == 6'h0; endproperty
  a_dma_pulse: assert property (p_dma_pulse) else $error("dma request longer than one cycle");
  property p_b_hold; O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold; O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_b_time; I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID; endproperty
  a_b_time: assert property (p_b_time) else $error("write response late");
  property p_r_time; I_ARVALID && O_ARREADY |=> O_RVALID; endproperty
  a_r_time: assert property (p_r_time) else $error("read response late");
  property p_wr_busy; O_BVALID |-> !O_AWREADY && !O_WREADY; endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write accepted while response pending");
  property p_rd_busy; O_RVALID |-> !O_ARREADY; endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("read accepted while data pending");
  property p_slverr;
    I_ARVALID && O_ARREADY && I_ARADDR == 8'h08 |=> O_RRESP == atc_pkg::RESP_SLVERR && O_RDATA == 32'h0;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped read not refused");
  c_capture: cover property (O_DMA_REQ[5]);
  c_toggle: cover property ($changed(O_CH_OUT[0]));
  c_slverr: cover property (O_RVALID && O_RRESP == atc_pkg::RESP_SLVERR);
endmodule : atc_monitor

// [verif/atc_pin_model.sv]
`timescale 1ns/1ps
module atc_pin_model (
  input wire logic clk,
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  output logic [5:0] pin_in
);
  logic [5:0] drv = 6'h0;
  // Each pin shows whichever side enables its driver
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
  task automatic wave(input int h, input int w, input int l);
    drv[h] <= 1'b1;
    repeat (w) @(posedge clk);
    drv[h] <= 1'b0;
    repeat (l) @(posedge clk);
    drv[h] <= 1'b1;
    repeat (20) @(posedge clk);
  endtask : wave
endmodule : atc_pin_model

// [verif/atc_top_tb_top.sv]
`timescale 1ns/1ps
module atc_top_tb_top;
  logic clk, rst, gate, awv, wv, bready, arv, rready, irq, awr, wrdy, bv, ardy, rv;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [31:0] c [3];
  logic [5:0] pin_in, ch_out, ch_oe, dma;
  logic [1:0] bresp, rresp;
  int err_count, n_checks, cyc;
  atc_top i_atc_top (.I_CORE_CLK(clk), .I_RST(rst), .I_CLK_GATE_EN(gate), .I_CH_IN(pin_in),
    .O_CH_OUT(ch_out), .O_CH_OE(ch_oe), .O_DMA_REQ(dma), .O_IRQ(irq), .I_AWADDR(awaddr), .I_AWVALID(awv),
    .O_AWREADY(awr), .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wv), .O_WREADY(wrdy), .O_BRESP(bresp),
    .O_BVALID(bv), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arv), .O_ARREADY(ardy), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(rready));
  atc_pin_model i_atc_pin_model (.clk(clk), .pin_out(ch_out), .pin_oe(ch_oe), .pin_in(pin_in));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    fork
      begin do @(posedge clk); while (awr !== 1'b1); awv <= 1'b0; end
      begin do @(posedge clk); while (wrdy !== 1'b1); wv <= 1'b0; end
    join
    // The edge that samples bvalid high with bready up is the handshake
    do @(posedge clk); while (bv !== 1'b1);
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (ardy !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic span(output int na, output int nlow, output int nhigh);
    na = 0;
    nlow = 0;
    nhigh = 0;
    // One full centre-aligned period with a reload of 19
    repeat (38) begin
      @(posedge clk);
      if (ch_out[0] === 1'b1) na++;
      if (ch_out[1:0] === 2'b00) nlow++;
      if (ch_out[1:0] === 2'b11) nhigh++;
    end
  endtask : span
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rd(atc_pkg::OFF_ARR, d, r);
    chk(d, {16'h0, atc_pkg::ARR_RST});
    rd(atc_pkg::OFF_CR, d, r);
    chk(d, atc_pkg::CR_RST);
    rd(8'h08, d, r);
    chk({30'h0, r}, {30'h0, atc_pkg::RESP_SLVERR});
    $display("test reset_values done");
  endtask : t_reset
  task automatic t_capture;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    wr(8'h2c, 32'h0000_02b2);
    wr(atc_pkg::OFF_CR, 32'h0000_0021);
    fork
      i_atc_pin_model.wave(5, 30, 40);
      for (int i = 0; i < 3; i++) begin
        // Each request pulse fetches one fixed-source capture word
        do @(posedge clk); while (dma[5] !== 1'b1);
        rd(atc_pkg::OFF_CCR[5], c[i], r);
      end
    join
    chk(c[1] - c[0], 32'd30);
    chk(c[2] - c[0], 32'd70);
    rd(atc_pkg::OFF_ISR, d, r);
    chk(d & 32'h20, 32'h20);
    chk({31'h0, irq}, 32'h1);
    wr(atc_pkg::OFF_ICR, 32'hffff_ffdf);
    rd(atc_pkg::OFF_ISR, d, r);
    chk(d & 32'h20, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(8'h2c, 32'h0000_0212);
    n = 0;
    fork
      i_atc_pin_model.wave(5, 10, 20);
      repeat (90) begin @(posedge clk); if (dma[5] === 1'b1) n++; end
    join
    chk(n, 32'd1);
    chk({31'h0, irq}, 32'h0);
    $display("test capture done");
  endtask : t_capture
  task automatic t_toggle;
    logic p;
    int n;
    wr(atc_pkg::OFF_ARR, 32'd9);
    wr(atc_pkg::OFF_CNT, 32'd0);
    wr(atc_pkg::OFF_CCR[0], 32'd3);
    wr(atc_pkg::OFF_FLTR, 32'h4);
    wr(atc_pkg::OFF_DTR, 32'h200);
    p = ch_out[0];
    do @(posedge clk); while (ch_out[0] === p);
    p = ch_out[0];
    n = 0;
    do begin @(posedge clk); n++; end while (ch_out[0] === p);
    chk(n, 32'd10);
    chk({31'h0, ch_oe[0]}, 32'h1);
    chk({31'h0, ch_oe[5]}, 32'h0);
    wr(atc_pkg::OFF_DTR, 32'h0);
    repeat (3) @(posedge clk);
    chk({30'h0, ch_oe[0], ch_out[0]}, 32'h0);
    $display("test toggle done");
  endtask : t_toggle
  task automatic t_pwm;
    int na;
    int nl;
    int nh;
    // Reload 19 in centre mode gives a 38-cycle period; A is active for counts 2..13
    wr(atc_pkg::OFF_ARR, 32'd19);
    wr(atc_pkg::OFF_CCR[0], 32'd2);
    wr(atc_pkg::OFF_CCR[1], 32'd14);
    wr(atc_pkg::OFF_FLTR, 32'h66);
    wr(atc_pkg::OFF_DTR, 32'h200);
    wr(atc_pkg::OFF_CR, 32'h131);
    repeat (40) @(posedge clk);
    span(na, nl, nh);
    chk(na, 32'd24);
    chk(nl + nh, 32'd0);
    wr(atc_pkg::OFF_FLTR, 32'h6e);
    repeat (4) @(posedge clk);
    span(na, nl, nh);
    chk(na, 32'd14);
    wr(atc_pkg::OFF_FLTR, 32'h67);
    repeat (4) @(posedge clk);
    span(na, nl, nh);
    chk(na, 32'd14);
    wr(atc_pkg::OFF_DTR, 32'h303);
    repeat (40) @(posedge clk);
    span(na, nl, nh);
    chk(nh, 32'd0);
    chk({31'h0, nl != 0}, 32'h1);
    $display("test pwm done");
  endtask : t_pwm
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    {rst, gate, awv, wv, bready, arv, rready} = 7'b1100000;
    {awaddr, araddr, wdata} = 48'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_capture();
    t_toggle();
    t_pwm();
    complete_run();
  end
  initial cyc = 0;
endmodule : atc_top_tb_top
bind atc_top atc_monitor i_atc_monitor (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .O_CH_OUT(O_CH_OUT),
  .O_CH_OE(O_CH_OE), .O_DMA_REQ(O_DMA_REQ), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID),
  .O_WREADY(O_WREADY), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR),
  .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID),
  .I_RREADY(I_RREADY));
